// ### logic/reset_source_regs.vh
// Register map, field positions and timing counts of the reset cause
// and memory remap block. Definitions only; included by bare name.
`ifndef RESET_SOURCE_REGS_VH
`define RESET_SOURCE_REGS_VH

// ==========================================================
// Register byte addresses
`define ADDR_REMAP_CTRL      32'hffff0220
`define ADDR_CAUSE_STATUS    32'hffff0230
`define ADDR_CAUSE_CLEAR     32'hffff0234

// ==========================================================
// Register select codes from the address decoder
`define SEL_NONE             2'h0
`define SEL_REMAP            2'h1
`define SEL_STATUS           2'h2
`define SEL_CLEAR            2'h3

// ==========================================================
// Reset cause status and clear fields
`define CAUSE_W              4
`define CAUSE_POR_BIT        0
`define CAUSE_WDT_BIT        1
`define CAUSE_SW_BIT         2
`define CAUSE_EXT_BIT        3
`define CAUSE_POR_VALUE      4'h1

// ==========================================================
// Remap control fields
`define REMAP_SRAM_BIT       0
`define REMAP_RESET_VALUE    1'h0

// ==========================================================
// Timing: internal reset pulse length
`define CLK_PERIOD_NS        100
`define RESET_HOLD_NS        1600
`define RESET_HOLD_CYC       ((`RESET_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### logic/level_sync2.v
// Two-flop level synchroniser for inputs from outside the clock domain.
// Assumes each bit is a slow level; no pulse shorter than two clocks.
`timescale 1ns/1ps

module level_sync2 #(
    parameter       WIDTH     = 1,
    parameter       RST_VALUE = 1'b0
) (
    // Clock and control
    input  wire               ref_clk_in,
    input  wire               rst_in,
    input  wire               ce_in,
    // Data
    input  wire [WIDTH-1:0]   async_in,
    output wire [WIDTH-1:0]   sync_out
);

    reg [WIDTH-1:0] meta_r;
    reg [WIDTH-1:0] sync_r;

    // ==========================================================
    // Synchroniser stages
    // First stage is read only by the second one
    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            meta_r <= {WIDTH{RST_VALUE}};
            sync_r <= {WIDTH{RST_VALUE}};
        end else if (ce_in) begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;

endmodule // level_sync2

// ### logic/reset_source_and_remap.v
// Reset cause recorder, internal reset sequencer and remap control bit.
// Assumes a single-cycle register port on ref_clk_in, a watchdog pulse
// from logic on the same clock, and pins/monitor levels from outside.
//
// How it works
// - Setting remap bit 0 maps SRAM at address zero.
// - Any reset clears the remap bit so program memory sits at address zero again.
// - Four reset sources are told apart: pin, power-on, watchdog and software.
// - An external pin reset sets cause bit 3.
// - A watchdog timeout sets cause bit 1.
// - A power-on reset sets cause bit 0.
// - Writing one to cause bit 2 starts a software reset and that bit reads one.
// - Cause bits 7 to 4 always read zero.
// - A write-only clear register with the same layout clears each bit written one.
// - With the software bit set, a clear write that leaves it set resets again.
// - Every reset defaults pins and reruns boot; all but power-on keep the cause bits; only power-on resets the watchdog.
// - RAM counts as invalid after a reset that follows a serial code download.
// - With low-voltage flag checking on, RAM survives power-on only if the flag reads one.
// - The remap register holds only bit 0 read/write, bits 7 to 1 read zero, and is set up after boot.
// - Every reset restores program memory to the bottom of the map.
`timescale 1ns/1ps
`include "reset_source_regs.vh"

module reset_source_and_remap #(
    parameter       HOLD_CYCLES = `RESET_HOLD_CYC,
    parameter       CNT_W       = 8
) (
    // Clock, reset, enable
    input  wire           ref_clk_in,
    input  wire           rst_in,
    input  wire           ce_in,
    // Register port
    input  wire [31:0]    addr_in,
    input  wire           wr_in,
    input  wire           rd_in,
    input  wire [7:0]     wdata_in,
    output wire [7:0]     rdata_out,
    // Reset sources
    input  wire           ext_reset_n_in,
    input  wire           wdt_timeout_in,
    // RAM validity inputs
    input  wire           lin_download_in,
    input  wire           low_voltage_flag_enable_in,
    input  wire           low_voltage_flag_in,
    // System outputs
    output wire           sys_reset_out,
    output wire           wdt_reset_out,
    output wire           kernel_boot_out,
    output wire           remap_sram_out,
    output wire           ram_valid_out
);

    // ==========================================================
    // Sequencer states and constants
    localparam ST_RUN  = 1'b0;
    localparam ST_HOLD = 1'b1;
    localparam [31:0]      HOLD_LAST_W = HOLD_CYCLES - 1;
    localparam [CNT_W-1:0] HOLD_LAST   = HOLD_LAST_W[CNT_W-1:0];
    localparam [CNT_W-1:0] CNT_ONE     = {{(CNT_W-1){1'b0}}, 1'b1};

    // ==========================================================
    // Address decode, shared by read and write paths
    function [1:0] reg_sel;
        input [31:0] a;
        begin
            case (a)
                `ADDR_REMAP_CTRL:   reg_sel = `SEL_REMAP;
                `ADDR_CAUSE_STATUS: reg_sel = `SEL_STATUS;
                `ADDR_CAUSE_CLEAR:  reg_sel = `SEL_CLEAR;
                default:            reg_sel = `SEL_NONE;
            endcase
        end
    endfunction

    // ==========================================================
    // Declarations
    reg                  state_r,      state_nxt;
    reg [CNT_W-1:0]      cnt_r,        cnt_nxt;
    reg [`CAUSE_W-1:0]   cause_r,      cause_nxt;
    reg                  remap_r,      remap_nxt;
    reg                  por_r,        por_nxt;
    reg                  lin_pend_r,   lin_pend_nxt;
    reg                  ram_valid_r,  ram_valid_nxt;
    reg                  boot_r,       boot_nxt;
    reg                  sys_reset_r,  sys_reset_nxt;
    reg                  wdt_reset_r,  wdt_reset_nxt;
    reg [7:0]            rdata_r,      rdata_nxt;
    reg                  sw_req;
    reg                  ext_evt;
    reg                  wdt_evt;
    wire [1:0]           sel;
    wire [2:0]           pins_sync;

    assign sel = reg_sel(addr_in);

    // ==========================================================
    // Pin and monitor synchronisers
    // Pin idles high, so it resets to the inactive level
    level_sync2 #(
        .WIDTH     (3),
        .RST_VALUE (1'b0)
    ) u_pin_sync (
        .ref_clk_in (ref_clk_in),
        .rst_in     (rst_in),
        .ce_in      (ce_in),
        .async_in   ({low_voltage_flag_in, low_voltage_flag_enable_in, ~ext_reset_n_in}),
        .sync_out   (pins_sync)
    );

    // ==========================================================
    // Next-state logic
    always @* begin
        state_nxt     = state_r;
        cnt_nxt       = cnt_r;
        cause_nxt     = cause_r;
        remap_nxt     = remap_r;
        por_nxt       = por_r;
        lin_pend_nxt  = lin_pend_r | lin_download_in;
        ram_valid_nxt = ram_valid_r;
        boot_nxt      = 1'b0;
        rdata_nxt     = 8'h00;
        sw_req        = 1'b0;
        ext_evt       = pins_sync[0];
        wdt_evt       = wdt_timeout_in;

        // Register port is dead while the system is held in reset
        if (state_r == ST_RUN) begin
            if (wr_in && sel == `SEL_STATUS && wdata_in[`CAUSE_SW_BIT]) begin
                sw_req = 1'b1;
            end
            if (wr_in && sel == `SEL_CLEAR) begin
                cause_nxt = cause_r & ~wdata_in[`CAUSE_W-1:0];
                if (cause_r[`CAUSE_SW_BIT] && !wdata_in[`CAUSE_SW_BIT]) begin
                    sw_req = 1'b1;
                end
            end
            if (wr_in && sel == `SEL_REMAP) begin
                remap_nxt = wdata_in[`REMAP_SRAM_BIT];
            end
            if (rd_in) begin
                case (sel)
                    `SEL_REMAP:  rdata_nxt = {7'h00, remap_r};
                    `SEL_STATUS: rdata_nxt = {4'h0, cause_r};
                    default:     rdata_nxt = 8'h00;
                endcase
            end
        end

        // Cause capture; a set here wins over a clear in the same cycle
        if (ext_evt) begin
            cause_nxt[`CAUSE_EXT_BIT] = 1'b1;
        end
        if (wdt_evt) begin
            cause_nxt[`CAUSE_WDT_BIT] = 1'b1;
        end
        if (sw_req) begin
            cause_nxt[`CAUSE_SW_BIT] = 1'b1;
        end

        // Sequencer: any source restarts the hold period
        if (ext_evt || wdt_evt || sw_req) begin
            state_nxt     = ST_HOLD;
            cnt_nxt       = {CNT_W{1'b0}};
            remap_nxt     = `REMAP_RESET_VALUE;
            por_nxt       = por_r & (state_r == ST_HOLD);
            ram_valid_nxt = 1'b0;
        end else begin
            case (state_r)
                ST_HOLD: begin
                    if (cnt_r == HOLD_LAST) begin
                        state_nxt    = ST_RUN;
                        boot_nxt     = 1'b1;
                        lin_pend_nxt = 1'b0;
                        por_nxt      = 1'b0;
                        if (lin_pend_r) begin
                            ram_valid_nxt = 1'b0;
                        end else if (por_r) begin
                            ram_valid_nxt = pins_sync[1] & pins_sync[2];
                        end else begin
                            ram_valid_nxt = 1'b1;
                        end
                    end else begin
                        cnt_nxt = cnt_r + CNT_ONE;
                    end
                end
                default: begin
                    state_nxt = ST_RUN;
                end
            endcase
        end

        // Pins default on every reset; watchdog reset only on power-on
        sys_reset_nxt = (state_nxt == ST_HOLD);
        wdt_reset_nxt = (state_nxt == ST_HOLD) && por_nxt;
    end

    // ==========================================================
    // State registers
    // Power-on wipes the cause history; other resets keep it
    always @(posedge ref_clk_in) begin
        if (rst_in) begin
            state_r     <= ST_HOLD;
            cnt_r       <= {CNT_W{1'b0}};
            cause_r     <= `CAUSE_POR_VALUE;
            remap_r     <= `REMAP_RESET_VALUE;
            por_r       <= 1'b1;
            lin_pend_r  <= 1'b0;
            ram_valid_r <= 1'b0;
            boot_r      <= 1'b0;
            sys_reset_r <= 1'b1;
            wdt_reset_r <= 1'b1;
            rdata_r     <= 8'h00;
        end else if (ce_in) begin
            state_r     <= state_nxt;
            cnt_r       <= cnt_nxt;
            cause_r     <= cause_nxt;
            remap_r     <= remap_nxt;
            por_r       <= por_nxt;
            lin_pend_r  <= lin_pend_nxt;
            ram_valid_r <= ram_valid_nxt;
            boot_r      <= boot_nxt;
            sys_reset_r <= sys_reset_nxt;
            wdt_reset_r <= wdt_reset_nxt;
            rdata_r     <= rdata_nxt;
        end
    end

    // ==========================================================
    // Outputs, all straight from flip-flops
    assign rdata_out       = rdata_r;
    assign sys_reset_out   = sys_reset_r;
    assign wdt_reset_out   = wdt_reset_r;
    assign kernel_boot_out = boot_r;
    assign remap_sram_out  = remap_r;
    assign ram_valid_out   = ram_valid_r;

endmodule // reset_source_and_remap

// ### bench/reset_source_and_remap_chk.sv
// Assertions on the ports of the reset cause and remap block.
// Assumes one clock, sync reset, and ce_in high while a reset is held.
`timescale 1ns/1ps
`include "reset_source_regs.vh"

module reset_source_and_remap_chk #(
    parameter HOLD_CYCLES = 16
) (
    // Clock and control
    input logic        ref_clk_in,
    input logic        rst_in,
    input logic        ce_in,
    // Register port
    input logic [31:0] addr_in,
    input logic        wr_in,
    input logic        rd_in,
    input logic [7:0]  wdata_in,
    input logic [7:0]  rdata_out,
    // Reset source and system outputs
    input logic        wdt_timeout_in,
    input logic        sys_reset_out,
    input logic        wdt_reset_out,
    input logic        kernel_boot_out,
    input logic        remap_sram_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    // ==========================================================
    // Helpers: access acceptance and length of the current hold
    logic       acc;
    logic [7:0] hold_cnt_r;
    assign acc = ce_in && !sys_reset_out;
    // Wraps only if a pin is held low for hundreds of cycles
    // Cleared while sys_reset_out is low and in power-on reset, so each hold counts from its start
    always_ff @(posedge ref_clk_in)
        hold_cnt_r <= (rst_in || !sys_reset_out) ? 8'h00 : hold_cnt_r + 8'h01;

    property p_sw_req;
        acc && wr_in && addr_in == `ADDR_CAUSE_STATUS && wdata_in[2] |=> sys_reset_out;
    endproperty
    a_sw_req: assert property (p_sw_req) else $error("no software reset");
    property p_wdt_evt;
        ce_in && wdt_timeout_in |=> sys_reset_out;
    endproperty
    a_wdt_evt: assert property (p_wdt_evt) else $error("no watchdog reset");
    property p_remap_set;
        acc && wr_in && addr_in == `ADDR_REMAP_CTRL && wdata_in[0] && !wdt_timeout_in
            |=> remap_sram_out;
    endproperty
    a_remap_set: assert property (p_remap_set) else $error("remap not set");
    property p_remap_clr;
        sys_reset_out |-> !remap_sram_out;
    endproperty
    a_remap_clr: assert property (p_remap_clr) else $error("remap kept in reset");
    property p_status_rsvd;
        acc && rd_in && addr_in == `ADDR_CAUSE_STATUS |=> rdata_out[7:4] == 4'h0;
    endproperty
    a_status_rsvd: assert property (p_status_rsvd) else $error("upper bits set");
    property p_hold;
        sys_reset_out && hold_cnt_r < HOLD_CYCLES - 1 |=> sys_reset_out;
    endproperty
    a_hold: assert property (p_hold) else $error("reset too short");
    property p_boot;
        $fell(sys_reset_out) |-> kernel_boot_out ##1 !kernel_boot_out;
    endproperty
    a_boot: assert property (p_boot) else $error("boot pulse wrong");
    property p_wdt_por;
        $rose(sys_reset_out) |-> !wdt_reset_out;
    endproperty
    a_wdt_por: assert property (p_wdt_por) else $error("watchdog reset");
endmodule // reset_source_and_remap_chk

bind reset_source_and_remap reset_source_and_remap_chk #(.HOLD_CYCLES(HOLD_CYCLES)) u_chk (
    .ref_clk_in, .rst_in, .ce_in, .addr_in, .wr_in, .rd_in, .wdata_in, .rdata_out,
    .wdt_timeout_in, .sys_reset_out, .wdt_reset_out, .kernel_boot_out, .remap_sram_out);

// ### bench/reset_source_and_remap_tb.sv
// Self-checking bench for the reset cause and remap block.
// Assumes the single-cycle register port and a 10 MHz clock.
`timescale 1ns/1ps
`include "reset_source_regs.vh"

module reset_source_and_remap_tb;
    localparam HOLD = 4;
    logic        ref_clk_in = 1'b0, rst_in = 1'b1, ce_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0;
    logic [31:0] addr_in = 32'h0;
    logic [7:0]  wdata_in = 8'h00, rdata_out;
    logic        ext_reset_n_in = 1'b1, wdt_timeout_in = 1'b0, lin_download_in = 1'b0;
    logic        low_voltage_flag_enable_in = 1'b1, low_voltage_flag_in = 1'b1;
    logic        sys_reset_out, wdt_reset_out, kernel_boot_out, remap_sram_out, ram_valid_out;
    int          errors = 0, n_tests = 0, n;

    // Short hold keeps the run brief
    reset_source_and_remap #(.HOLD_CYCLES(HOLD)) u_dut (
        .ref_clk_in, .rst_in, .ce_in, .addr_in, .wr_in, .rd_in, .wdata_in, .rdata_out,
        .ext_reset_n_in, .wdt_timeout_in, .lin_download_in, .low_voltage_flag_enable_in,
        .low_voltage_flag_in, .sys_reset_out, .wdt_reset_out, .kernel_boot_out,
        .remap_sram_out, .ram_valid_out);

    always #50 ref_clk_in = ~ref_clk_in;

    // ==========================================================
    // Access and compare tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge ref_clk_in);
        wr_in <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [31:0] a, input logic [7:0] exp);
        @(posedge ref_clk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge ref_clk_in);
        rd_in <= 1'b0;
        #1;
        chk(rdata_out, exp);
    endtask
    // Counts edges to release; zero skips the count (pin sync delay)
    task automatic rel(input logic [7:0] exp_n);
        n = 0;
        while (sys_reset_out === 1'b1 && n < 100) begin
            @(posedge ref_clk_in);
            #1;
            n++;
        end
        if (n >= 100) errors++;
        if (exp_n != 8'h00) chk(n[7:0], exp_n);
        chk(kernel_boot_out, 1'b1);
        @(posedge ref_clk_in);
        #1;
        chk(kernel_boot_out, 1'b0);
    endtask
    task automatic por(input logic flag);
        @(posedge ref_clk_in);
        rst_in <= 1'b1;
        low_voltage_flag_in <= flag;
        repeat (4) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        #1;
        chk(wdt_reset_out, 1'b1);
        rel(HOLD);
    endtask
    task automatic end_of_test;
        $display("Checks %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    initial begin
        por(1'b1);
        chk(ram_valid_out, 1'b1);
        rd(`ADDR_CAUSE_STATUS, 8'h01);
        rd(`ADDR_REMAP_CTRL, 8'h00);
        wr(`ADDR_CAUSE_CLEAR, 8'h01);
        rd(`ADDR_CAUSE_STATUS, 8'h00);
        rd(`ADDR_CAUSE_CLEAR, 8'h00);
        wr(`ADDR_REMAP_CTRL, 8'h01);
        chk(remap_sram_out, 1'b1);
        rd(`ADDR_REMAP_CTRL, 8'h01);
        wr(32'hffff0238, 8'hff);
        wr(`ADDR_CAUSE_STATUS, 8'hfb);
        chk(sys_reset_out, 1'b0);
        rd(32'hffff0238, 8'h00);
        rd(`ADDR_CAUSE_STATUS, 8'h00);
        // Watchdog after a serial download leaves RAM untrusted
        @(posedge ref_clk_in);
        lin_download_in <= 1'b1;
        @(posedge ref_clk_in);
        lin_download_in <= 1'b0;
        wdt_timeout_in <= 1'b1;
        @(posedge ref_clk_in);
        wdt_timeout_in <= 1'b0;
        #1;
        chk(remap_sram_out, 1'b0);
        rel(HOLD);
        chk(ram_valid_out, 1'b0);
        chk(wdt_reset_out, 1'b0);
        rd(`ADDR_CAUSE_STATUS, 8'h02);
        // Software request, then clears with and without its bit
        wr(`ADDR_CAUSE_STATUS, 8'h04);
        rel(HOLD);
        chk(ram_valid_out, 1'b1);
        rd(`ADDR_CAUSE_STATUS, 8'h06);
        wr(`ADDR_CAUSE_CLEAR, 8'h02);
        rel(HOLD);
        rd(`ADDR_CAUSE_STATUS, 8'h04);
        wr(`ADDR_CAUSE_CLEAR, 8'h04);
        chk(sys_reset_out, 1'b0);
        // Clock enable low freezes state, so a watchdog pulse then is lost
        @(posedge ref_clk_in);
        ce_in <= 1'b0;
        wdt_timeout_in <= 1'b1;
        @(posedge ref_clk_in);
        wdt_timeout_in <= 1'b0;
        ce_in <= 1'b1;
        #1;
        chk(sys_reset_out, 1'b0);
        // External pin held low past the synchroniser
        @(posedge ref_clk_in);
        ext_reset_n_in <= 1'b0;
        repeat (5) @(posedge ref_clk_in);
        ext_reset_n_in <= 1'b1;
        #1;
        chk(sys_reset_out, 1'b1);
        rel(8'h00);
        rd(`ADDR_CAUSE_STATUS, 8'h08);
        // Power-on with the low-voltage flag down drops old causes
        por(1'b0);
        chk(ram_valid_out, 1'b0);
        rd(`ADDR_CAUSE_STATUS, 8'h01);
        // Power-on with flag checking off never trusts RAM
        @(posedge ref_clk_in);
        low_voltage_flag_enable_in <= 1'b0;
        por(1'b1);
        chk(ram_valid_out, 1'b0);
        end_of_test();
    end

    // Whole sequence needs about a hundred cycles
    initial begin
        repeat (3000) @(posedge ref_clk_in);
        errors++;
        end_of_test();
    end
endmodule // reset_source_and_remap_tb
